// File: u2_defs.vh
// Constants, register map and field layout of the secondary serial port.
// Overview of operation
// - Two mode bits pick modes zero to three
// - No framing check, no address matching
// - Modes 2/3 multiproc: ninth bit must be one
// - Mode 1 multiproc: stop bit must be valid
// - Reception only while receive enable set
// - Modes 2/3 send software ninth bit
// - Received ninth bit: bit nine or stop
// - Transmit flag set per mode, software clears
// - Receive flag set per mode, software clears
// - Baud timer counts only while run set
// - Double-rate bit doubles modes 1-3 rate
// - Clock select: system clock or divided twelve
// - Modes 1/3 rate from timer reload value
// - Mode 2 rate clock/64 or clock/32
// - Mode 0 rate clock/12 or clock/2
// - Primary port may use this baud timer
// - Clock-out pin: 50% wave from overflows
// - Both ports run independently unless sharing
// - Buffer write starts transmit, latches ninth bit
// - Sixteen-times sampling, majority of 7/8/9
// - Final shift loads only if flag clear
`ifndef U2_DEFS_VH
`define U2_DEFS_VH

// Register indices; the byte address is four times the index.
`define U2_IDX_AUX        10'h08E
`define U2_IDX_CONTROL    10'h099
`define U2_IDX_BUFFER     10'h09A
`define U2_IDX_AUX_TWO    10'h0A6
`define U2_IDX_RELOAD     10'h0BA

// Reset values.
`define U2_RST_BYTE       8'h00

// Control register fields.
`define U2_C_MODE_HI      7
`define U2_C_MODE_LO      6
`define U2_C_MULTIPROC    5
`define U2_C_RX_EN        4
`define U2_C_TX_NINTH     3
`define U2_C_RX_NINTH     2
`define U2_C_TX_DONE      1
`define U2_C_RX_DONE      0

// Auxiliary register fields.
`define U2_A_TIMER_SUBST  7
`define U2_A2_MODE0_SPEED 5
`define U2_A2_RUN         4
`define U2_A2_DOUBLE      3
`define U2_A2_CLK_SEL     2
`define U2_A2_CLKOUT_EN   1

// Timing counts in system clocks.
`define U2_PRESCALE_LAST  4'hB
`define U2_M0_HALF_SLOW   3'h5
`define U2_M0_HALF_FAST   3'h0
`define U2_M2_DIV_SLOW    2'h3
`define U2_M2_DIV_FAST    2'h1

// Frame positions in sixteenths and bits.
`define U2_PH_S1          4'h7
`define U2_PH_S2          4'h8
`define U2_PH_S3          4'h9
`define U2_PH_LAST        4'hF
`define U2_STOP_8BIT      4'h9
`define U2_STOP_9BIT      4'hA
`define U2_M0_LAST_BIT    3'h7

`endif

// File: u2_baud_timer.v
// Dedicated baud timer with prescaler and square-wave clock output.
`timescale 1ns/1ps
`default_nettype none
`include "u2_defs.vh"
module u2_baud_timer #(
  parameter W = 8
) (
  input  wire         clk_in,
  input  wire         rst_in,
  input  wire         run_in,
  input  wire         clk_sel_in,
  input  wire         clkout_en_in,
  input  wire [W-1:0] reload_in,
  output wire         ovf_out,
  output reg          clkout_out
);
  reg  [3:0]   pre_q;    // Divide-by-twelve prescaler.
  reg  [W-1:0] cnt_q;    // Up-counter.
  wire         step;     // Counter advance enable.

  // The prescaler runs freely so the divided rate has a fixed phase.
  always @(posedge clk_in) begin
    if (rst_in || pre_q == `U2_PRESCALE_LAST) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  assign step    = run_in && (clk_sel_in || pre_q == `U2_PRESCALE_LAST);
  assign ovf_out = step && (&cnt_q);

  // Count up and reload on rollover; a stopped timer holds its value.
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= {W{1'b0}};
    end else if (ovf_out) begin
      cnt_q <= reload_in;
    end else if (step) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Toggling on each overflow gives an exact half duty wave.
  always @(posedge clk_in) begin
    if (rst_in || !clkout_en_in) begin
      clkout_out <= 1'b0;
    end else if (ovf_out) begin
      clkout_out <= ~clkout_out;
    end
  end
endmodule
`default_nettype wire

// File: u2_uart.v
// Secondary serial port with AHB-Lite register access.
`timescale 1ns/1ps
`default_nettype none
`include "u2_defs.vh"
module u2_uart (
  input  wire        MCLK_IN,
  input  wire        RESET_IN,
  input  wire        HSEL_IN,
  input  wire [31:0] HADDR_IN,
  input  wire [1:0]  HTRANS_IN,
  input  wire        HWRITE_IN,
  input  wire [2:0]  HSIZE_IN,
  input  wire [31:0] HWDATA_IN,
  input  wire        HREADY_IN,
  output wire [31:0] HRDATA_OUT,
  output wire        HREADYOUT_OUT,
  output wire        HRESP_OUT,
  output wire        SERIAL_TX_PIN_OUT,
  input  wire        SERIAL_RX_PIN_IN,
  output wire        SERIAL_RX_PIN_OUT,
  output wire        SERIAL_RX_PIN_OE_OUT,
  output wire        CLOCK_OUT_PIN_OUT,
  output wire        CLOCK_OUT_PIN_OE_OUT,
  input  wire        T1_OVF_IN,
  input  wire        TX_CLOCK_FROM_T2_IN,
  input  wire        RX_CLOCK_FROM_T2_IN,
  output wire        PRI_BAUD_OVF_OUT
);
  // Register state.
  reg  [7:3]  ctrl_q;     // Mode, multiproc, receive enable, transmit ninth bit.
  reg         rx9_q;      // Received ninth bit.
  reg         ti_q;       // Transmit done flag.
  reg         ri_q;       // Receive done flag.
  reg  [7:0]  rx_buf_q;   // Received byte as read by software.
  reg         subst_q;    // Primary port timer substitute.
  reg  [7:0]  aux2_q;     // Second auxiliary register.
  reg  [7:0]  reload_q;   // Baud timer reload value.
  // Bus state.
  reg         wr_q;       // Write data phase pending.
  reg         rd_q;       // Read wait cycle pending.
  reg  [9:0]  idx_q;      // Latched register index.
  reg  [31:0] hrdata_q;   // Read data.
  reg  [7:0]  rd_val;     // Read mux result.
  // Transmit state for modes 1 to 3.
  reg  [7:0]  tx_byte_q;  // Byte waiting to go.
  reg         tx9_q;      // Ninth bit latched at the buffer write.
  reg         tx_pend_q;  // Transmit requested.
  reg         tx_busy_q;  // Frame on the line.
  reg  [10:0] tx_sh_q;    // Outgoing frame shifter.
  reg  [3:0]  tx_cnt_q;   // Bits already sent.
  reg  [3:0]  tx_div_q;   // Transmit sixteenth counter.
  reg         tx_line_q;  // Transmit line level.
  // Receive state for modes 1 to 3.
  reg         rx_last_q;  // Previous sample for edge search.
  reg         rx_busy_q;  // Frame being received.
  reg  [3:0]  rx_ph_q;    // Sixteenth within the bit.
  reg  [3:0]  rx_cnt_q;   // Bit number, zero for start.
  reg  [1:0]  rx_smp_q;   // First two of three samples.
  reg  [7:0]  rx_sh_q;    // Incoming data shifter.
  reg         rx_bit9_q;  // Incoming ninth bit.
  // Rate generation.
  reg  [1:0]  m2_div_q;   // Mode 2 divider.
  reg         half_q;     // Timer overflow halver.
  // Mode 0 shift engine.
  reg         m0_busy_q;  // Shifting in progress.
  reg         m0_tx_q;    // Direction, high when sending.
  reg         m0_req_q;   // Receive requested.
  reg         m0_pend_q;  // Send requested.
  reg         m0_clk_q;   // Shift clock level.
  reg  [2:0]  m0_div_q;   // Half-bit divider.
  reg  [2:0]  m0_bit_q;   // Bit number.
  reg  [7:0]  m0_sh_q;    // Shift register.

  wire [7:0] wbyte  = HWDATA_IN[7:0];
  wire [1:0] mode   = {ctrl_q[`U2_C_MODE_HI], ctrl_q[`U2_C_MODE_LO]};
  wire       mode0  = (mode == 2'b00);
  wire       mode1  = (mode == 2'b01);
  wire       mode2  = (mode == 2'b10);
  wire       sm2    = ctrl_q[`U2_C_MULTIPROC];
  wire       ren    = ctrl_q[`U2_C_RX_EN];
  wire       dbl    = aux2_q[`U2_A2_DOUBLE];
  wire       addr_ph = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire       we_ctrl = wr_q && (idx_q == `U2_IDX_CONTROL);
  wire       we_buf  = wr_q && (idx_q == `U2_IDX_BUFFER);
  wire       ovf;     // Baud timer overflow pulse.
  wire       tick16;  // Sixteen-times bit rate enable.
  wire       tx_roll = tick16 && (&tx_div_q);
  wire [3:0] stop_ix = mode1 ? `U2_STOP_8BIT : `U2_STOP_9BIT;
  wire       vote;    // Majority of the three samples.
  wire       rx_take; // Frame accepted at the stop bit.
  wire       rx_stop; // Stop bit sample point.
  wire       m0_tick; // Half-bit enable in mode 0.
  wire       m0_done; // Last mode 0 shift.
  wire       ti_set;
  wire       ri_set;

  // One read wait state lets a read follow a write and still see it.
  assign HREADYOUT_OUT = !rd_q;
  assign HRESP_OUT     = 1'b0;
  assign HRDATA_OUT    = hrdata_q;

  // Address phase capture; only whole-word transfers are expected.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      idx_q <= 10'h000;
    end else begin
      wr_q <= addr_ph && HWRITE_IN;
      rd_q <= addr_ph && !HWRITE_IN;
      if (addr_ph) begin
        idx_q <= HADDR_IN[11:2];
      end
    end
  end

  // Read mux; unmapped indices read zero.
  always @* begin
    case (idx_q)
      `U2_IDX_CONTROL: rd_val = {ctrl_q, rx9_q, ti_q, ri_q};
      `U2_IDX_BUFFER:  rd_val = rx_buf_q;
      `U2_IDX_AUX:     rd_val = {subst_q, 7'h00};
      `U2_IDX_AUX_TWO: rd_val = aux2_q;
      `U2_IDX_RELOAD:  rd_val = reload_q;
      default:         rd_val = 8'h00;
    endcase
  end

  // Read data is captured in the wait cycle and held until the next read.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_q) begin
      hrdata_q <= {24'h000000, rd_val};
    end
  end

  // Software registers; hardware flag sets win over a software clear.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      ctrl_q   <= 5'h00;
      rx9_q    <= 1'b0;
      ti_q     <= 1'b0;
      ri_q     <= 1'b0;
      subst_q  <= 1'b0;
      aux2_q   <= `U2_RST_BYTE;
      reload_q <= `U2_RST_BYTE;
    end else begin
      if (we_ctrl) begin
        ctrl_q <= wbyte[7:3];
      end
      if (wr_q && idx_q == `U2_IDX_AUX) begin
        subst_q <= wbyte[`U2_A_TIMER_SUBST];
      end
      if (wr_q && idx_q == `U2_IDX_AUX_TWO) begin
        aux2_q <= wbyte;
      end
      if (wr_q && idx_q == `U2_IDX_RELOAD) begin
        reload_q <= wbyte;
      end
      if (rx_take) begin
        rx9_q <= mode1 ? vote : rx_bit9_q;
      end else if (we_ctrl) begin
        rx9_q <= wbyte[`U2_C_RX_NINTH];
      end
      ti_q <= ti_set | (we_ctrl ? wbyte[`U2_C_TX_DONE] : ti_q);
      ri_q <= ri_set | (we_ctrl ? wbyte[`U2_C_RX_DONE] : ri_q);
    end
  end

  // Received byte buffer, loaded by either engine.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      rx_buf_q <= `U2_RST_BYTE;
    end else if (rx_take) begin
      rx_buf_q <= rx_sh_q;
    end else if (m0_done && !m0_tx_q) begin
      rx_buf_q <= {SERIAL_RX_PIN_IN, m0_sh_q[7:1]};
    end
  end

  u2_baud_timer #(
    .W (8)
  ) u_timer (
    .clk_in       (MCLK_IN),
    .rst_in       (RESET_IN),
    .run_in       (aux2_q[`U2_A2_RUN]),
    .clk_sel_in   (aux2_q[`U2_A2_CLK_SEL]),
    .clkout_en_in (aux2_q[`U2_A2_CLKOUT_EN]),
    .reload_in    (reload_q),
    .ovf_out      (ovf),
    .clkout_out   (CLOCK_OUT_PIN_OUT)
  );

  // The clock-out pin is taken over only while enabled.
  assign CLOCK_OUT_PIN_OE_OUT = aux2_q[`U2_A2_CLKOUT_EN];
  // The primary port keeps its own timer unless it hands over to ours.
  assign PRI_BAUD_OVF_OUT = (subst_q && !TX_CLOCK_FROM_T2_IN && !RX_CLOCK_FROM_T2_IN)
                            ? ovf : T1_OVF_IN;

  // Mode 2 divider and overflow halver produce the sixteen-times tick.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      m2_div_q <= 2'h0;
      half_q   <= 1'b0;
    end else begin
      m2_div_q <= m2_div_q + 2'h1;
      if (ovf) begin
        half_q <= ~half_q;
      end
    end
  end

  assign tick16 = mode2 ? (dbl ? ((m2_div_q & `U2_M2_DIV_FAST) == `U2_M2_DIV_FAST)
                              : (m2_div_q == `U2_M2_DIV_SLOW))
                        : (!mode0 && ovf && (dbl || half_q));

  // Transmitter: the frame starts on the next sixteenth rollover.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      tx_div_q  <= 4'h0;
      tx_pend_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 11'h7FF;
      tx_cnt_q  <= 4'h0;
      tx_line_q <= 1'b1;
      tx_byte_q <= 8'h00;
      tx9_q     <= 1'b0;
    end else begin
      if (tick16) begin
        tx_div_q <= tx_div_q + 4'h1;
      end
      if (we_buf) begin
        tx_byte_q <= wbyte;
        tx9_q     <= ctrl_q[`U2_C_TX_NINTH];
      end
      if (we_buf && !mode0) begin
        tx_pend_q <= 1'b1;
      end else if (tx_roll && !tx_busy_q && tx_pend_q) begin
        tx_pend_q <= 1'b0;
        tx_busy_q <= 1'b1;
        tx_cnt_q  <= 4'h0;
        tx_line_q <= 1'b0;
        tx_sh_q   <= {1'b1, mode1 ? 1'b1 : tx9_q, tx_byte_q, 1'b0};
      end else if (tx_roll && tx_busy_q) begin
        tx_cnt_q  <= tx_cnt_q + 4'h1;
        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
        tx_line_q <= tx_sh_q[1];
        if (tx_cnt_q == stop_ix) begin
          tx_busy_q <= 1'b0;
          tx_line_q <= 1'b1;
        end
      end
    end
  end

  // Mode 0 clocks on the transmit pin; the other modes send frames there.
  assign SERIAL_TX_PIN_OUT = mode0 ? m0_clk_q : tx_line_q;

  assign vote    = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] | rx_smp_q[1]) & SERIAL_RX_PIN_IN;
  assign rx_stop = tick16 && rx_busy_q && rx_ph_q == `U2_PH_S3 && rx_cnt_q == stop_ix;
  // No framing or address check is made here.
  assign rx_take = rx_stop && !ri_q
                   && (!sm2 || (mode1 ? vote : rx_bit9_q));
  assign ti_set  = (tx_roll && tx_busy_q && tx_cnt_q + 4'h1 == stop_ix)
                   || (m0_done && m0_tx_q);
  assign ri_set  = rx_take || (m0_done && !m0_tx_q);

  // Receiver: edge search, three-sample vote, shift, and accept.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      rx_last_q <= 1'b1;
      rx_busy_q <= 1'b0;
      rx_ph_q   <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rx_smp_q  <= 2'b11;
      rx_sh_q   <= 8'h00;
      rx_bit9_q <= 1'b0;
    end else if (tick16) begin
      rx_last_q <= SERIAL_RX_PIN_IN;
      if (!rx_busy_q) begin
        if (ren && rx_last_q && !SERIAL_RX_PIN_IN) begin
          rx_busy_q <= 1'b1;
          rx_ph_q   <= 4'h0;
          rx_cnt_q  <= 4'h0;
        end
      end else begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_ph_q == `U2_PH_S1) begin
          rx_smp_q[0] <= SERIAL_RX_PIN_IN;
        end
        if (rx_ph_q == `U2_PH_S2) begin
          rx_smp_q[1] <= SERIAL_RX_PIN_IN;
        end
        if (rx_ph_q == `U2_PH_S3) begin
          if (rx_cnt_q == 4'h0 && vote) begin
            rx_busy_q <= 1'b0;
          end else if (rx_cnt_q > 4'h0 && rx_cnt_q < `U2_STOP_8BIT) begin
            rx_sh_q <= {vote, rx_sh_q[7:1]};
          end else if (rx_cnt_q == `U2_STOP_8BIT && !mode1) begin
            rx_bit9_q <= vote;
          end
        end
        if (rx_ph_q == `U2_PH_LAST) begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == stop_ix) begin
            rx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  assign m0_tick = m0_div_q == (aux2_q[`U2_A2_MODE0_SPEED] ? `U2_M0_HALF_FAST
                                                          : `U2_M0_HALF_SLOW);
  assign m0_done = m0_busy_q && m0_tick && m0_clk_q && m0_bit_q == `U2_M0_LAST_BIT;
  assign SERIAL_RX_PIN_OUT    = m0_sh_q[0];
  assign SERIAL_RX_PIN_OE_OUT = m0_busy_q && m0_tx_q;

  // Mode 0 shift engine: clock low then high per bit, data LSB first.
  always @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      m0_busy_q <= 1'b0;
      m0_tx_q   <= 1'b0;
      m0_req_q  <= 1'b0;
      m0_pend_q <= 1'b0;
      m0_clk_q  <= 1'b1;
      m0_div_q  <= 3'h0;
      m0_bit_q  <= 3'h0;
      m0_sh_q   <= 8'hFF;
    end else begin
      m0_div_q <= m0_tick ? 3'h0 : m0_div_q + 3'h1;
      if (we_buf && mode0) begin
        m0_pend_q <= 1'b1;
        m0_sh_q   <= wbyte;
      end
      if (we_ctrl) begin
        m0_req_q <= wbyte[`U2_C_RX_EN] && !wbyte[`U2_C_RX_DONE];
      end
      if (!mode0) begin
        m0_busy_q <= 1'b0;
        m0_clk_q  <= 1'b1;
        m0_pend_q <= 1'b0;
        m0_req_q  <= 1'b0;
      end else if (!m0_busy_q && m0_tick && (m0_pend_q || (m0_req_q && !ri_q))) begin
        m0_busy_q <= 1'b1;
        m0_tx_q   <= m0_pend_q;
        m0_pend_q <= 1'b0;
        m0_req_q  <= 1'b0;
        m0_bit_q  <= 3'h0;
        m0_clk_q  <= 1'b0;
      end else if (m0_busy_q && m0_tick) begin
        m0_clk_q <= ~m0_clk_q;
        if (m0_clk_q) begin
          m0_bit_q <= m0_bit_q + 3'h1;
          m0_sh_q  <= {m0_tx_q ? 1'b1 : SERIAL_RX_PIN_IN, m0_sh_q[7:1]};
          if (m0_bit_q == `U2_M0_LAST_BIT) begin
            m0_busy_q <= 1'b0;
            m0_clk_q  <= 1'b1; // Park the shift clock high, its rest level.
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: u2_uart_props.sv
// Port-level checks for the secondary serial port.
`timescale 1ns/1ps
`default_nettype none
module u2_uart_props (
  input wire logic        MCLK_IN,
  input wire logic        RESET_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic [2:0]  HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        SERIAL_TX_PIN_OUT,
  input wire logic        SERIAL_RX_PIN_IN,
  input wire logic        SERIAL_RX_PIN_OUT,
  input wire logic        SERIAL_RX_PIN_OE_OUT,
  input wire logic        CLOCK_OUT_PIN_OUT,
  input wire logic        CLOCK_OUT_PIN_OE_OUT,
  input wire logic        T1_OVF_IN,
  input wire logic        TX_CLOCK_FROM_T2_IN,
  input wire logic        RX_CLOCK_FROM_T2_IN,
  input wire logic        PRI_BAUD_OVF_OUT
);
  // A transfer is taken only when the slave is selected and the bus is ready.
  wire logic take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RESET_IN);
  AST_OKAY: assert property (HRESP_OUT == 1'b0) else $error("slave response not okay");
  AST_READ_WAIT: assert property (take && !HWRITE_IN |=> !HREADYOUT_OUT)
    else $error("read data phase has no wait state");
  AST_ONE_WAIT: assert property (!HREADYOUT_OUT |=> HREADYOUT_OUT)
    else $error("wait state longer than one cycle");
  AST_WRITE_NOWAIT: assert property (take && HWRITE_IN |=> HREADYOUT_OUT)
    else $error("write data phase stalled");
  AST_UPPER_ZERO: assert property (HRDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // Read data may only move on the edge that ends a wait state.
  AST_HOLD_DATA: assert property (HREADYOUT_OUT && $past(HREADYOUT_OUT) && !$past(RESET_IN)
    |-> $stable(HRDATA_OUT)) else $error("read data moved between reads");
  AST_CLKOUT_OFF: assert property (!CLOCK_OUT_PIN_OE_OUT && !$past(CLOCK_OUT_PIN_OE_OUT)
    |-> !CLOCK_OUT_PIN_OUT) else $error("clock output active while disabled");
  AST_CLKOUT_RISE: assert property ($rose(CLOCK_OUT_PIN_OUT)
    |-> CLOCK_OUT_PIN_OE_OUT || $past(CLOCK_OUT_PIN_OE_OUT)) else $error("clock rose unenabled");
  AST_PRI_T1: assert property (TX_CLOCK_FROM_T2_IN || RX_CLOCK_FROM_T2_IN
    |-> PRI_BAUD_OVF_OUT == T1_OVF_IN) else $error("primary overflow not from timer one");
  CV_READ: cover property (take && !HWRITE_IN ##1 !HREADYOUT_OUT);
  CV_CLKOUT: cover property ($rose(CLOCK_OUT_PIN_OUT));
  CV_FRAME: cover property ($fell(SERIAL_TX_PIN_OUT));
  CV_SHIFT: cover property ($rose(SERIAL_RX_PIN_OE_OUT));
endmodule
`default_nettype wire

// File: u2_remote.sv
// Remote serial transceiver facing the secondary port's line pins.
`timescale 1ns/1ps
`default_nettype none
module u2_remote (
  input  wire logic clk_in,   // System clock used as the bit timebase.
  input  wire logic line_in,  // Port's transmit line.
  output var  logic line_out  // Port's receive line.
);
  // The line idles high between frames, as a pulled-up link would.
  initial line_out = 1'b1;
  // Sends nb bits LSB first, each held bc clocks, then idles one bit time.
  // The idle gap lets the far receiver rearm before the next start edge.
  task automatic send(input logic [10:0] f, input int nb, input int bc);
    for (int i = 0; i < nb; i++) begin
      line_out <= f[i];
      repeat (bc) @(posedge clk_in);
    end
    line_out <= 1'b1;
    repeat (bc) @(posedge clk_in);
  endtask
  // Waits for a start edge, then samples each bit in its middle.
  task automatic recv(input int nb, input int bc, output logic [10:0] f);
    int n;
    f = 11'h7FF;
    n = 0;
    while (line_in !== 1'b0 && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    repeat (bc / 2) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_in;
      repeat (bc) @(posedge clk_in);
    end
  endtask
endmodule
`default_nettype wire

// File: u2_uart_tb.sv
// Self-checking bench for the secondary serial port.
`timescale 1ns/1ps
`default_nettype none
module u2_uart_tb;
  localparam logic [31:0] A_AUX = 32'h238, A_CTL = 32'h264, A_BUF = 32'h268;
  localparam logic [31:0] A_AUX2 = 32'h298, A_REL = 32'h2E8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  t1_cnt = 3'h0;
  logic        t2_rx = 1'b0;
  logic        t2_tx = 1'b0;
  wire  [31:0] hrdata;
  wire         hready, hresp, tx_line, rx_line, m0_data, m0_oe, ckout, ck_oe, pri_ovf;
  wire         rx_wire = m0_oe ? m0_data : rx_line;  // Shared receive pin level.
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic [10:0] fr;
  int          n;
  always #5 clk = ~clk;
  // Primary timer overflow stand-in: one pulse every eight clocks.
  always @(posedge clk) t1_cnt <= t1_cnt + 3'h1;
  u2_uart u2_uart_i (.MCLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .SERIAL_TX_PIN_OUT(tx_line), .SERIAL_RX_PIN_IN(rx_wire), .SERIAL_RX_PIN_OUT(m0_data),
    .SERIAL_RX_PIN_OE_OUT(m0_oe), .CLOCK_OUT_PIN_OUT(ckout), .CLOCK_OUT_PIN_OE_OUT(ck_oe),
    .T1_OVF_IN(t1_cnt == 3'h0), .TX_CLOCK_FROM_T2_IN(t2_tx), .RX_CLOCK_FROM_T2_IN(t2_rx),
    .PRI_BAUD_OVF_OUT(pri_ovf));
  u2_remote u2_remote_i (.clk_in(clk), .line_in(tx_line), .line_out(rx_line));
  // Compares and counts; an unknown never passes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One single word transfer; read data lands in rd at the final edge.
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Counts clocks until the clock-out pin changes, capped at 1000.
  task automatic half(output int k);
    logic v;
    v = ckout;
    k = 0;
    while (ckout === v && k < 1000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // Reset values, a stored value, and an unmapped place that reads zero.
  task automatic t_regs;
    logic [31:0] ads[4] = '{A_AUX, A_CTL, A_AUX2, A_REL};
    foreach (ads[i]) begin
      bus(1'b0, ads[i], 8'h00);
      chk(rd, 32'h0);
    end
    bus(1'b1, A_REL, 8'h5A);
    bus(1'b0, A_REL, 8'h00);
    chk(rd, 32'h5A);
    bus(1'b1, 32'h400, 8'hFF);
    bus(1'b0, 32'h400, 8'h00);
    chk(rd, 32'h0);
  endtask
  // Mode 2 transmit at both fixed rates with the software ninth bit.
  task automatic t_m2_tx;
    bus(1'b1, A_CTL, 8'h88);
    bus(1'b1, A_BUF, 8'hA5);
    u2_remote_i.recv(11, 64, fr);
    chk(fr, {2'b11, 8'hA5, 1'b0});
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[1], 1'b1);
    bus(1'b1, A_CTL, 8'h80);
    bus(1'b1, A_AUX2, 8'h08);
    bus(1'b1, A_BUF, 8'h3C);
    u2_remote_i.recv(11, 32, fr);
    chk(fr, {2'b10, 8'h3C, 1'b0});
  endtask
  // Mode 3 receive from the timer with multiprocessor filtering.
  task automatic t_m3_rx;
    bus(1'b1, A_REL, 8'hFC);
    bus(1'b1, A_AUX2, 8'h14);
    bus(1'b1, A_CTL, 8'hF0);
    repeat (300) @(posedge clk); // The timer starts from zero, so wait for steady ticks.
    u2_remote_i.send({2'b10, 8'h55, 1'b0}, 11, 128);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[0], 1'b0);
    u2_remote_i.send({2'b11, 8'h96, 1'b0}, 11, 128);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[2:0], 3'b101);
    u2_remote_i.send({2'b11, 8'h11, 1'b0}, 11, 128);
    bus(1'b0, A_BUF, 8'h00);
    chk(rd, 32'h96);
  endtask
  // Mode 1: receive enable, stop-bit filter, and no framing check.
  task automatic t_m1_rx;
    bus(1'b1, A_CTL, 8'h40);
    u2_remote_i.send({1'b1, 8'h77, 1'b0}, 10, 128);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[0], 1'b0);
    bus(1'b1, A_CTL, 8'h70);
    u2_remote_i.send({1'b0, 8'h77, 1'b0}, 10, 128);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[0], 1'b0);
    bus(1'b1, A_CTL, 8'h50);
    u2_remote_i.send({1'b0, 8'h77, 1'b0}, 10, 128);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[2:0], 3'b001);
    bus(1'b0, A_BUF, 8'h00);
    chk(rd, 32'h77);
  endtask
  // Clock output, timer source, run control and overflow sharing.
  task automatic t_clk;
    bus(1'b1, A_AUX2, 8'h02);
    bus(1'b1, A_REL, 8'hFE);
    bus(1'b1, A_AUX2, 8'h16);
    half(n);
    half(n);
    chk(n, 2);
    half(n);
    chk(n, 2);
    bus(1'b1, A_AUX, 8'h80);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += pri_ovf;
    end
    chk(n, 20);
    t2_rx <= 1'b1;
    t2_tx <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += pri_ovf;
    end
    chk(n, 5);
    bus(1'b1, A_AUX2, 8'h12);
    half(n);
    half(n);
    chk(n, 24);
    bus(1'b1, A_AUX2, 8'h02);
    half(n);
    chk(n, 1000);
  endtask
  // Fast mode 0 transmit: eight bits, LSB first, two clocks per bit.
  task automatic t_m0_tx;
    logic [7:0] b;
    time        t0;
    bus(1'b1, A_CTL, 8'h00);
    bus(1'b1, A_AUX2, 8'h20);
    bus(1'b1, A_BUF, 8'h3C);
    for (int i = 0; i < 8; i++) begin
      while (tx_line !== 1'b0) @(posedge clk);
      while (tx_line !== 1'b1) @(posedge clk);
      b[i] = m0_data;
      if (i == 0) t0 = $time;
    end
    chk(b, 8'h3C);
    chk($time - t0, 140);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[1], 1'b1);
    bus(1'b1, A_CTL, 8'h10);
    u2_remote_i.send(11'h000, 1, 40);
    bus(1'b0, A_BUF, 8'h00);
    chk(rd, 32'h00);
    bus(1'b0, A_CTL, 8'h00);
    chk(rd[0], 1'b1);
  endtask
  // Main sequence: two clocks of reset, then every scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_m2_tx();
    t_m3_rx();
    t_m1_rx();
    t_clk();
    t_m0_tx();
    complete_run();
  end
  // Watchdog set well beyond the expected run of about twelve thousand clocks.
  initial begin
    #500000;
    fail_count++;
    complete_run();
  end
endmodule
bind u2_uart u2_uart_props u2_uart_props_i (.*);
`default_nettype wire
